// >>> pieb_pkg.sv
// register map, field positions and reset values of the enable bank
package pieb_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_CONTROL = 10'h00b;
	localparam logic [9:0] IDX_FLAGS0 = 10'h08c;
	localparam logic [9:0] IDX_FLAGS1 = 10'h08d;
	localparam logic [9:0] IDX_FLAGS2 = 10'h08e;
	localparam logic [9:0] IDX_FLAGS3 = 10'h08f;
	localparam logic [9:0] IDX_FLAGS4 = 10'h090;
	localparam logic [9:0] IDX_ENABLE0 = 10'h096;
	localparam logic [9:0] IDX_ENABLE1 = 10'h097;
	localparam logic [9:0] IDX_ENABLE2 = 10'h098;
	localparam logic [9:0] IDX_ENABLE3 = 10'h099;
	localparam logic [9:0] IDX_ENABLE4 = 10'h09a;
	localparam logic [9:0] IDX_SUM_STATUS = 10'h0a0;
	localparam logic [9:0] IDX_SUM_CLEAR = 10'h0a1;
	localparam logic [9:0] IDX_SUM_ENABLE = 10'h0a2;

	// number of flag/enable register pairs
	localparam int NUM_BANKS = 5;

	// per bank index tables, bank 0 first
	localparam logic [9:0] FLAG_IDX [0:NUM_BANKS-1] = '{IDX_FLAGS0,
		IDX_FLAGS1, IDX_FLAGS2, IDX_FLAGS3, IDX_FLAGS4};
	localparam logic [9:0] ENABLE_IDX [0:NUM_BANKS-1] = '{IDX_ENABLE0,
		IDX_ENABLE1, IDX_ENABLE2, IDX_ENABLE3, IDX_ENABLE4};

	// implemented bits per bank; the rest read zero and never set
	localparam logic [7:0] IMPL_BANK0 = 8'h31;
	localparam logic [7:0] IMPL_BANK1 = 8'hfd;
	localparam logic [7:0] IMPL_BANK2 = 8'hff;
	localparam logic [7:0] IMPL_BANK3 = 8'hff;
	localparam logic [7:0] IMPL_BANK4 = 8'h3f;
	localparam logic [7:0] IMPL_MASK [0:NUM_BANKS-1] = '{IMPL_BANK0,
		IMPL_BANK1, IMPL_BANK2, IMPL_BANK3, IMPL_BANK4};

	// enable bank 1 fields
	localparam int EN1_TIMER3 = 5;
	localparam int EN1_TIMER1_GATE = 4;
	localparam int EN1_TIMER1 = 3;
	localparam int EN1_CLOCK_TUNING = 2;
	localparam int EN1_NONVOLATILE = 0;

	// interrupt control register fields
	localparam int CTL_GLOBAL_GATE = 7;
	localparam int CTL_PERIPH_GATE = 6;
	localparam int CTL_EDGE_SELECT = 0;
	localparam logic [7:0] CTL_IMPL = 8'hc1;
	localparam logic [7:0] CTL_RESET = 8'h01;

	// reset values of the banks
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [4:0] SUM_RESET = 5'h00;

endpackage

// >>> pieb_flag_bank.sv
`timescale 1ns/10ps
// one request flag register and its enable register
module pieb_flag_bank
	import pieb_pkg::*;
#(
	parameter logic [7:0] IMPL = 8'hff
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstN,
	// peripheral events, one-cycle pulses
	input wire logic [7:0] evt,
	// register writes
	input wire logic flagWr,
	input wire logic enWr,
	input wire logic [7:0] wrData,
	// state
	output logic [7:0] flags,
	output logic [7:0] enables,
	output logic pending,
	output logic newFlag
);

	logic [7:0] flag_reg;
	logic [7:0] flag_next;
	logic [7:0] en_reg;
	logic [7:0] en_next;

	// a bank with no implemented bit cannot serve any source
	if (IMPL == 8'h00) begin : g_check
		$error("pieb_flag_bank: empty implemented mask");
	end

	// event wins over a software write in the same cycle
	assign flag_next = ((flagWr ? wrData : flag_reg) | evt) & IMPL; // RULE9
	assign en_next = enWr ? (wrData & IMPL) : en_reg; // RULE6

	// flags and enables
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			flag_reg <= FLAG_RESET;
			en_reg <= ENABLE_RESET;
		end else begin
			flag_reg <= flag_next;
			en_reg <= en_next;
		end
	end

	assign flags = flag_reg;
	assign enables = en_reg;
	// per-source gating, 1 permits and 0 blocks
	assign pending = |(flag_reg & en_reg); // RULE11
	assign newFlag = |(evt & IMPL & ~flag_reg);

endmodule

// >>> pieb_enable_bank.sv
// Local design decision: the APB slave port.
`timescale 1ns/10ps
// Overview of operation
// (RULE1) bank 1-4 sources reach the core only while peripheral gate is set
// (RULE2) bank 1: bit5 timer3, 4 timer1 gate, 3 timer1, 2 tuning, 0 nvm
// (RULE3) enable bank 2 at index 0x98, eight sources, reset zero
// (RULE4) enable bank 3 at index 0x99, eight sources, reset zero
// (RULE5) enable bank 4 at index 0x9a, bits 5..0, upper two unimplemented
// (RULE6) enable bits read/write; 1 permits, 0 blocks the source
// (RULE7) request flags of bank 0 live at index 0x8c
// (RULE8) global gate clear blocks every interrupt, overriding all enables; here it gates irqVector only, irqSummary ignores it
// (RULE9) flags set on their event whatever the enables say
// (RULE10) bank 0 sources need only the global gate to vector
// (RULE11) request is OR of flag AND enable, then gated
module pieb_enable_bank
	import pieb_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// peripheral event pulses, one bank each
	input wire logic [7:0] evtBank0,
	input wire logic [7:0] evtBank1,
	input wire logic [7:0] evtBank2,
	input wire logic [7:0] evtBank3,
	input wire logic [7:0] evtBank4,
	// towards the core vectoring logic
	output logic irqVector,
	output logic globalIrqGate,
	output logic peripheralIrqGate,
	// summary interrupt for polling software
	output logic irqSummary
);

	// the bank stores enables and flags; the core does the vectoring
	// every flop behind rstN leaves reset two edges after rst_n rises, so the bus
	// must not start a setup before the third edge
	// the apb slave never inserts wait states: pready follows setup
	// flags are read/write so software can clear them; an event in the
	// same cycle as a clearing write wins, so no event is ever lost
	// the summary registers let polling software find a busy bank
	// without reading all five flag registers in turn
	// limitation: the edge select bit is only stored, no pin logic here
	// unimplemented bits are masked inside each bank, so they read zero
	// and can never raise a request, whatever software writes

	// reset release
	logic rstMeta_reg;
	logic rstSync_reg;
	logic rstN;

	// bus
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic [9:0] regIdx;
	logic aligned;
	logic setupPhase;
	logic wrStrobe;

	// control register
	logic [7:0] ctl_reg;
	logic [7:0] ctl_next;
	logic ctlHit;

	// summary interrupt
	logic [4:0] sumStat_reg;
	logic [4:0] sumStat_next;
	logic [4:0] sumEn_reg;
	logic [4:0] sumEn_next;
	logic sumStatHit;
	logic sumClrHit;
	logic sumEnHit;
	logic irqSummary_reg;
	logic irqSummary_next;

	// vector request
	logic irqVector_reg;
	logic irqVector_next;
	logic bank0Pending;
	logic periphPending;

	// per bank signals
	logic [7:0] evtAll [0:NUM_BANKS-1];
	logic [7:0] flagsAll [0:NUM_BANKS-1];
	logic [7:0] ensAll [0:NUM_BANKS-1];
	logic [NUM_BANKS-1:0] flagHit;
	logic [NUM_BANKS-1:0] enHit;
	logic [NUM_BANKS-1:0] pendAll;
	logic [NUM_BANKS-1:0] newAll;
	logic [7:0] rdChain [0:NUM_BANKS];
	logic anyHit;
	logic [7:0] rdByte;

	// reset is released through two flops, asserted at once
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_reg <= 1'b0;
			rstSync_reg <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSync_reg <= rstMeta_reg;
		end
	end
	assign rstN = rstSync_reg;

	// address decode; word index, misaligned addresses miss everything
	assign regIdx = paddr[11:2];
	assign aligned = (paddr[1:0] == 2'b00);
	assign ctlHit = aligned && (regIdx == IDX_CONTROL);
	assign sumStatHit = aligned && (regIdx == IDX_SUM_STATUS);
	assign sumClrHit = aligned && (regIdx == IDX_SUM_CLEAR);
	assign sumEnHit = aligned && (regIdx == IDX_SUM_ENABLE);

	// setup cycle prepares the answer; the access cycle finishes it
	assign setupPhase = psel && !penable;
	assign wrStrobe = psel && penable && pready_reg && pwrite;

	// event inputs gathered per bank
	assign evtAll[0] = evtBank0;
	assign evtAll[1] = evtBank1;
	assign evtAll[2] = evtBank2;
	assign evtAll[3] = evtBank3;
	assign evtAll[4] = evtBank4;
	assign rdChain[0] = 8'h00;

	// one flag/enable pair per bank
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		assign flagHit[b] = aligned && (regIdx == FLAG_IDX[b]); // RULE7
		assign enHit[b] = aligned && (regIdx == ENABLE_IDX[b]); // RULE3 RULE4 RULE5
		// read mux as an or-chain, hits are one-hot
		assign rdChain[b+1] = rdChain[b] |
			({8{flagHit[b]}} & flagsAll[b]) |
			({8{enHit[b]}} & ensAll[b]);
		pieb_flag_bank #(
			.IMPL(IMPL_MASK[b]) // RULE2 RULE5
		) u_bank (
			.clk(mclk),
			.rstN(rstN),
			.evt(evtAll[b]),
			.flagWr(wrStrobe && flagHit[b]),
			.enWr(wrStrobe && enHit[b]), // RULE6
			.wrData(pwdata[7:0]),
			.flags(flagsAll[b]),
			.enables(ensAll[b]),
			.pending(pendAll[b]),
			.newFlag(newAll[b])
		);
	end

	// unmapped addresses answer with an error; reads of them also return zero data
	assign anyHit = ctlHit || sumStatHit || sumClrHit || sumEnHit ||
		(|flagHit) || (|enHit);
	assign rdByte = rdChain[NUM_BANKS] |
		({8{ctlHit}} & ctl_reg) |
		({8{sumStatHit}} & {3'b000, sumStat_reg}) |
		({8{sumEnHit}} & {3'b000, sumEn_reg});
	assign prdata_next = (setupPhase && !pwrite) ? {24'h000000, rdByte} :
		prdata_reg;
	assign pready_next = setupPhase;
	assign pslverr_next = setupPhase ? !anyHit : 1'b0;

	// bus answer flops
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// control register; edge select is only stored here
	assign ctl_next = (wrStrobe && ctlHit) ? (pwdata[7:0] & CTL_IMPL) :
		ctl_reg;

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			ctl_reg <= CTL_RESET;
		end else begin
			ctl_reg <= ctl_next;
		end
	end

	// summary status: a bank that gains a new flag marks itself
	// set wins over the write-one clear in the same cycle
	assign sumStat_next = (sumStat_reg &
		~((wrStrobe && sumClrHit) ? pwdata[4:0] : 5'h00)) | newAll;
	assign sumEn_next = (wrStrobe && sumEnHit) ? pwdata[4:0] : sumEn_reg;
	assign irqSummary_next = |(sumStat_next & sumEn_next);

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			sumStat_reg <= SUM_RESET;
			sumEn_reg <= SUM_RESET;
			irqSummary_reg <= 1'b0;
		end else begin
			sumStat_reg <= sumStat_next;
			sumEn_reg <= sumEn_next;
			irqSummary_reg <= irqSummary_next;
		end
	end

	// vector request: bank 0 bypasses the peripheral gate
	assign bank0Pending = pendAll[0]; // RULE10
	assign periphPending = |pendAll[NUM_BANKS-1:1]; // RULE11
	// global gate overrides everything feeding irqVector
	assign irqVector_next = ctl_reg[CTL_GLOBAL_GATE] && // RULE8
		(bank0Pending ||
		(ctl_reg[CTL_PERIPH_GATE] && periphPending)); // RULE1

	// registered so the core sees a glitch-free level
	// one cycle of latency is traded for a level free of decode hazards
	// a cleared global gate drops the request at the next edge, no later
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			irqVector_reg <= 1'b0;
		end else begin
			irqVector_reg <= irqVector_next;
		end
	end

	// outputs straight from flops
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irqVector = irqVector_reg;
	assign globalIrqGate = ctl_reg[CTL_GLOBAL_GATE];
	assign peripheralIrqGate = ctl_reg[CTL_PERIPH_GATE];
	assign irqSummary = irqSummary_reg;

endmodule

// >>> pieb_core_model.sv
`timescale 1ns/10ps
// core side: takes one vector per rising request level
module pieb_core_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// request from the bank
	input wire logic irqVector,
	output int takenCount
);
	logic seen_reg;
	// level request, so count only the rise or a held level double counts
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			seen_reg <= 1'b0;
			takenCount <= 0;
		end else begin
			seen_reg <= irqVector;
			if (irqVector && !seen_reg)
				takenCount <= takenCount + 1;
		end
	end
endmodule

// >>> pieb_enable_bank_properties.sv
`timescale 1ns/10ps
// apb and gate checks at the bank's ports
module pieb_props
	import pieb_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// core side
	input wire logic irqVector,
	input wire logic globalIrqGate,
	input wire logic peripheralIrqGate
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// request phases
	sequence sSetup;
		psel && !penable;
	endsequence
	sequence sCtlWr;
		pready && pwrite && paddr == {IDX_CONTROL, 2'b00};
	endsequence
	a_ready_after_setup: assert property (sSetup |=> pready)
		else $error("ready missing");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready too long");
	a_upper_zero: assert property (pready && !pwrite |-> !prdata[31:8])
		else $error("upper read bits set");
	a_err_reads_zero: assert property (pslverr |-> pready &&
		(pwrite || !prdata)) else $error("bad error answer");
	a_misaligned_err: assert property (sSetup ##0 paddr[1:0] != 2'b00
		|=> pslverr) else $error("misaligned not refused");
	a_unmapped_err: assert property (sSetup ##0 paddr[11:2] > IDX_SUM_ENABLE
		|=> pslverr) else $error("unmapped not refused");
	a_gate_write: assert property (sCtlWr |=> globalIrqGate ==
		$past(pwdata[7]) && peripheralIrqGate == $past(pwdata[6]))
		else $error("gates not written");
	a_global_blocks: assert property (!$past(globalIrqGate) |-> !irqVector)
		else $error("vector without global gate");
endmodule
bind pieb_enable_bank pieb_props i_props (.mclk, .rst_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irqVector,
	.globalIrqGate, .peripheralIrqGate);

// >>> pieb_enable_bank_bench.sv
`timescale 1ns/10ps
module pieb_enable_bank_bench
	import pieb_pkg::*;
;
	logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, errVal;
	logic irqVector, globalIrqGate, peripheralIrqGate, irqSummary;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdVal;
	logic [7:0] evt [0:4];
	int mismatches, compares, taken;
	pieb_enable_bank i_dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .evtBank0(evt[0]),
		.evtBank1(evt[1]), .evtBank2(evt[2]), .evtBank3(evt[3]),
		.evtBank4(evt[4]), .irqVector, .globalIrqGate, .peripheralIrqGate,
		.irqSummary);
	pieb_core_model i_core (.mclk, .rst_n, .irqVector, .takenCount(taken));
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; waits on pready, never on a fixed count
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		if (pready !== 1'b1)
			chk({31'h0, pready}, 32'h1);
		rdVal = prdata;
		errVal = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		bus(1'b1, {i, 2'b00}, d);
	endtask
	task automatic rd(input logic [9:0] i, input logic [31:0] e);
		bus(1'b0, {i, 2'b00}, 32'h0);
		chk(rdVal, e);
	endtask
	// one-cycle event, then time for flag and vector registers
	task automatic pulse(input int b, input logic [7:0] v);
		@(posedge mclk);
		evt[b] <= v;
		@(posedge mclk);
		evt[b] <= 8'h00;
		repeat (3) @(posedge mclk);
	endtask
	task automatic irq(input logic e);
		repeat (2) @(posedge mclk);
		chk({31'h0, irqVector}, {31'h0, e});
	endtask
	task automatic t_reset;
		rd(IDX_CONTROL, 32'h01);
		rd(IDX_ENABLE1, 32'h00);
		rd(IDX_ENABLE2, 32'h00);
		rd(IDX_ENABLE3, 32'h00);
		rd(IDX_ENABLE4, 32'h00);
		rd(IDX_FLAGS0, 32'h00);
	endtask
	task automatic t_rw;
		logic [7:0] impl [1:4] = '{8'hfd, 8'hff, 8'hff, 8'h3f};
		for (int b = 1; b < 5; b++) begin
			wr(ENABLE_IDX[b], 32'hffff_ffff);
			rd(ENABLE_IDX[b], {24'h0, impl[b]});
		end
		bus(1'b0, 12'hffc, 32'h0);
		chk({31'h0, errVal}, 32'h1);
		bus(1'b1, {IDX_ENABLE4, 2'b01}, 32'h0);
		chk({31'h0, errVal}, 32'h1);
		rd(IDX_ENABLE4, 32'h3f);
		for (int b = 1; b < 5; b++)
			wr(ENABLE_IDX[b], 32'h0);
	endtask
	task automatic t_gate;
		wr(IDX_ENABLE2, 32'h08);
		wr(IDX_CONTROL, 32'h80);
		pulse(2, 8'h08);
		rd(IDX_FLAGS2, 32'h08);
		irq(1'b0);
		wr(IDX_CONTROL, 32'hc0);
		irq(1'b1);
		wr(IDX_CONTROL, 32'h40);
		irq(1'b0);
		wr(IDX_FLAGS2, 32'h0);
		wr(IDX_ENABLE0, 32'h20);
		wr(IDX_CONTROL, 32'h80);
		pulse(0, 8'h20);
		irq(1'b1);
		wr(IDX_FLAGS0, 32'h0);
		irq(1'b0);
		wr(IDX_ENABLE0, 32'h0);
	endtask
	task automatic t_bank1;
		logic [7:0] bits [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
		wr(IDX_CONTROL, 32'hc0);
		foreach (bits[k]) begin
			wr(IDX_ENABLE1, 32'h0);
			pulse(1, bits[k]);
			irq(1'b0);
			wr(IDX_ENABLE1, {24'h0, bits[k]});
			irq(1'b1);
			wr(IDX_FLAGS1, 32'h0);
		end
	endtask
	// summary line: raise, mask, clear
	task automatic t_sum;
		wr(IDX_SUM_CLEAR, 32'h1f);
		rd(IDX_SUM_STATUS, 32'h00);
		chk({31'h0, irqSummary}, 32'h0);
		wr(IDX_SUM_ENABLE, 32'h04);
		pulse(2, 8'h01);
		chk({31'h0, irqSummary}, 32'h1);
		wr(IDX_SUM_ENABLE, 32'h00);
		irq(1'b0);
		chk({31'h0, irqSummary}, 32'h0);
		wr(IDX_SUM_ENABLE, 32'h04);
		wr(IDX_SUM_CLEAR, 32'h04);
		rd(IDX_SUM_STATUS, 32'h00);
		chk({31'h0, irqSummary}, 32'h0);
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// hang guard, far beyond the few hundred cycles needed
	initial begin
		#100us;
		mismatches++;
		print_verdict();
	end
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		foreach (evt[k]) evt[k] = 8'h00;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_rw();
		t_gate();
		t_bank1();
		t_sum();
		chk(taken, 32'd7);
		print_verdict();
	end
endmodule
